//--- hdl/lcd_vt_pkg.sv
// Purpose: constants and carriers for the lcd vertical timing and output block
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes: register offsets are byte addresses on the plain register port
// Function
// - 4-bit writable rgb pin arrangement, resets zero
// - dither enable bit, resets one, readable
// - three 3-bit per-color output line counts
// - zero line count means eight lines
// - code 01 swaps after current line
// - code 10 swaps after current frame
// - swap field reads zero only when safe
// - 12-bit sync phase b lines, resets ten
// - 12-bit sync phase a lines, resets zero
// - 12-bit active lines per frame, resets 0x110
// - 12-bit line offset before active, resets 0xc
// - 12-bit total lines per frame, resets 0x124
// - rotation never alters touch transform
// - pixel clock divides main clock; zero stops
// - 12-bit line total cycles, resets 0x224
package lcd_vt_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] LINE_TOTAL_OFS = 8'h2c;
  localparam logic [7:0] FRAME_TOTAL_OFS = 8'h40;
  localparam logic [7:0] FRAME_OFFSET_OFS = 8'h44;
  localparam logic [7:0] FRAME_ACTIVE_OFS = 8'h48;
  localparam logic [7:0] VSYNC_A_OFS = 8'h4c;
  localparam logic [7:0] VSYNC_B_OFS = 8'h50;
  localparam logic [7:0] SWAP_OFS = 8'h54;
  localparam logic [7:0] ROTATE_OFS = 8'h58;
  localparam logic [7:0] COLOR_LINES_OFS = 8'h5c;
  localparam logic [7:0] DITHER_OFS = 8'h60;
  localparam logic [7:0] ARRANGE_OFS = 8'h64;
  localparam logic [7:0] PCLK_DIV_OFS = 8'h70;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] LINE_TOTAL_RST = 12'h224;
  localparam logic [11:0] FRAME_TOTAL_RST = 12'h124;
  localparam logic [11:0] FRAME_OFFSET_RST = 12'h00c;
  localparam logic [11:0] FRAME_ACTIVE_RST = 12'h110;
  localparam logic [11:0] VSYNC_A_RST = 12'h000;
  localparam logic [11:0] VSYNC_B_RST = 12'h00a;
  localparam logic [8:0] COLOR_LINES_RST = 9'h000;
  localparam logic DITHER_RST = 1'h1;
  localparam logic [3:0] ARRANGE_RST = 4'h0;
  localparam logic [7:0] PCLK_DIV_RST = 8'h00;
  localparam logic [2:0] ROTATE_RST = 3'h0;

  // ----------------------------------------------------------------
  // field positions and codes
  // ----------------------------------------------------------------
  localparam int RED_LSB = 6;
  localparam int GREEN_LSB = 3;
  localparam int BLUE_LSB = 0;
  localparam logic [1:0] SWAP_LINE = 2'h1;
  localparam logic [1:0] SWAP_FRAME = 2'h2;

  // swap request state
  typedef enum logic [1:0] {SWAP_IDLE, SWAP_WAIT_LINE, SWAP_WAIT_FRAME} swap_e;

  // timing settings carried to the line counter
  typedef struct packed {
    logic [11:0] frame_total;
    logic [11:0] frame_offset;
    logic [11:0] frame_active;
    logic [11:0] vsync_a;
    logic [11:0] vsync_b;
  } vert_cfg_s;

  // rgb pixel triple
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } rgb_s;

endpackage

//--- hdl/pclk_divider.sv
// Purpose: one-cycle pixel clock enable pulse from main clock
// Assumes: divider value taken live; zero stops the pulse
// Notes: the pulse replaces a real second clock
`timescale 1ns/1ps
module pclk_divider #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // control
  input wire logic [DIV_W-1:0] div_i,
  // enable out
  output logic pix_en_o
);

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  wire wrap = (cnt_q >= div_i - 1'b1);

  // counter restarts when divider changes below it
  assign cnt_d = wrap ? '0 : cnt_q + 1'b1;

  // divide main clock, zero divider stops output
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      pix_en_o <= 1'b0;
    end else begin
      cnt_q <= (div_i == '0) ? '0 : cnt_d;
      pix_en_o <= (div_i != '0) && wrap;
    end
  end

  a_stop_when_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (div_i == '0) |=> !pix_en_o) else $error("pixel enable with zero divider");

endmodule

//--- hdl/color_conditioner.sv
// Purpose: per-color truncation, dither and pin arrangement
// Assumes: fed one pixel per pixel enable
// Notes: arrangement codes above 5 fall back to plain order
`timescale 1ns/1ps
module color_conditioner (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // control
  input wire logic en_i,
  input wire logic dither_i,
  input wire logic [8:0] lines_i,
  input wire logic [3:0] arrange_i,
  input wire logic [1:0] pos_i,
  // data
  input wire lcd_vt_pkg::rgb_s pix_i,
  output lcd_vt_pkg::rgb_s pix_o
);

  // zero count means full eight lines
  function automatic logic [7:0] trim(input logic [7:0] v, input logic [2:0] n,
                                      input logic dith, input logic [1:0] pos);
    logic [3:0] bits;
    logic [7:0] mask;
    logic [8:0] sum;
    bits = (n == 3'h0) ? 4'h8 : {1'b0, n};
    mask = 8'hff << (4'h8 - bits);
    sum = {1'b0, v};
    // ordered 2x2 offset below the kept lsb, saturating
    if (dith && bits != 4'h8) begin
      sum = {1'b0, v} + 9'(({6'h00, pos} << (4'h8 - bits)) >> 2);
    end
    if (sum[8]) begin
      sum = 9'h0ff;
    end
    trim = sum[7:0] & mask;
  endfunction

  lcd_vt_pkg::rgb_s cut;
  lcd_vt_pkg::rgb_s arr;

  // per-color line counts and dithering
  assign cut.r = trim(pix_i.r, lines_i[lcd_vt_pkg::RED_LSB +: 3], dither_i, pos_i);
  assign cut.g = trim(pix_i.g, lines_i[lcd_vt_pkg::GREEN_LSB +: 3], dither_i, pos_i);
  assign cut.b = trim(pix_i.b, lines_i[lcd_vt_pkg::BLUE_LSB +: 3], dither_i, pos_i);

  // pin arrangement selects color order
  always_comb begin
    case (arrange_i)
      4'h1: arr = '{r: cut.r, g: cut.b, b: cut.g};
      4'h2: arr = '{r: cut.g, g: cut.r, b: cut.b};
      4'h3: arr = '{r: cut.g, g: cut.b, b: cut.r};
      4'h4: arr = '{r: cut.b, g: cut.r, b: cut.g};
      4'h5: arr = '{r: cut.b, g: cut.g, b: cut.r};
      default: arr = cut;
    endcase
  end

  // registered pixel output
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pix_o <= '0;
    end else if (en_i) begin
      pix_o <= arr;
    end
  end

endmodule

//--- hdl/lcd_vert_timing.sv
// Purpose: register file, line and frame counters, swap handshake, rgb out
// Assumes: plain register port, read data one cycle after read strobe
// Notes: pixel source is an input; blanked outside active region
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module lcd_vert_timing #(
  parameter int CNT_W = 12,
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // pixel source
  input wire lcd_vt_pkg::rgb_s pix_i,
  // panel
  output logic pix_en_o,
  output logic vert_sync_phase_a_o,
  output logic vert_sync_phase_b_o,
  output logic line_active_o,
  output logic frame_start_o,
  output lcd_vt_pkg::rgb_s rgb_o,
  // rendering side
  output logic list_swap_o,
  output logic [2:0] screen_rotation_setting_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] line_total_cycles_q;
  lcd_vt_pkg::vert_cfg_s cfg_q;
  logic [8:0] color_line_counts_q;
  logic output_dither_enable_q;
  logic [3:0] rgb_pin_arrangement_q;
  logic [DIV_W-1:0] pclk_div_q;
  logic [2:0] screen_rotation_setting_q;
  logic [31:0] rdata_q;

  // decode strobes
  wire wr_line = wr_i && addr_i == lcd_vt_pkg::LINE_TOTAL_OFS;
  wire wr_total = wr_i && addr_i == lcd_vt_pkg::FRAME_TOTAL_OFS;
  wire wr_offset = wr_i && addr_i == lcd_vt_pkg::FRAME_OFFSET_OFS;
  wire wr_active = wr_i && addr_i == lcd_vt_pkg::FRAME_ACTIVE_OFS;
  wire wr_va = wr_i && addr_i == lcd_vt_pkg::VSYNC_A_OFS;
  wire wr_vb = wr_i && addr_i == lcd_vt_pkg::VSYNC_B_OFS;
  wire wr_swap = wr_i && addr_i == lcd_vt_pkg::SWAP_OFS;
  wire wr_rot = wr_i && addr_i == lcd_vt_pkg::ROTATE_OFS;
  wire wr_lines = wr_i && addr_i == lcd_vt_pkg::COLOR_LINES_OFS;
  wire wr_dith = wr_i && addr_i == lcd_vt_pkg::DITHER_OFS;
  wire wr_arr = wr_i && addr_i == lcd_vt_pkg::ARRANGE_OFS;
  wire wr_div = wr_i && addr_i == lcd_vt_pkg::PCLK_DIV_OFS;

  // setting registers, one write each
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      line_total_cycles_q <= lcd_vt_pkg::LINE_TOTAL_RST;
      cfg_q.frame_total <= lcd_vt_pkg::FRAME_TOTAL_RST;
      cfg_q.frame_offset <= lcd_vt_pkg::FRAME_OFFSET_RST;
      cfg_q.frame_active <= lcd_vt_pkg::FRAME_ACTIVE_RST;
      cfg_q.vsync_a <= lcd_vt_pkg::VSYNC_A_RST;
      cfg_q.vsync_b <= lcd_vt_pkg::VSYNC_B_RST;
      color_line_counts_q <= lcd_vt_pkg::COLOR_LINES_RST;
      output_dither_enable_q <= lcd_vt_pkg::DITHER_RST;
      rgb_pin_arrangement_q <= lcd_vt_pkg::ARRANGE_RST;
      pclk_div_q <= lcd_vt_pkg::PCLK_DIV_RST;
      screen_rotation_setting_q <= lcd_vt_pkg::ROTATE_RST;
    end else begin
      if (wr_line) line_total_cycles_q <= wdata_i[11:0];
      if (wr_total) cfg_q.frame_total <= wdata_i[11:0];
      if (wr_offset) cfg_q.frame_offset <= wdata_i[11:0];
      if (wr_active) cfg_q.frame_active <= wdata_i[11:0];
      if (wr_va) cfg_q.vsync_a <= wdata_i[11:0];
      if (wr_vb) cfg_q.vsync_b <= wdata_i[11:0];
      if (wr_lines) color_line_counts_q <= wdata_i[8:0];
      if (wr_dith) output_dither_enable_q <= wdata_i[0];
      if (wr_arr) rgb_pin_arrangement_q <= wdata_i[3:0];
      if (wr_div) pclk_div_q <= wdata_i[7:0];
      if (wr_rot) screen_rotation_setting_q <= wdata_i[2:0];
    end
  end

  // rotation reaches only the display path, no touch transform here
  assign screen_rotation_setting_o = screen_rotation_setting_q;

  // ----------------------------------------------------------------
  // pixel enable and horizontal counter
  // ----------------------------------------------------------------
  pclk_divider #(.DIV_W(DIV_W)) u_div (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .div_i(pclk_div_q),
    .pix_en_o(pix_en_o)
  );

  logic [CNT_W-1:0] hcnt_q;
  logic [CNT_W-1:0] vcnt_q;
  wire line_end = pix_en_o && (hcnt_q >= line_total_cycles_q - 1'b1);
  wire frame_end = line_end && (vcnt_q >= cfg_q.frame_total - 1'b1);

  // line counter advances per line, wraps at frame total
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      hcnt_q <= '0;
      vcnt_q <= '0;
    end else if (pix_en_o) begin
      hcnt_q <= line_end ? '0 : hcnt_q + 1'b1;
      if (frame_end) begin
        vcnt_q <= '0;
      end else if (line_end) begin
        vcnt_q <= vcnt_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // vertical regions, all compared against the line counter
  // ----------------------------------------------------------------
  wire [CNT_W:0] act_end = {1'b0, cfg_q.frame_offset} + {2'b00, cfg_q.frame_active[10:0]};
  assign vert_sync_phase_a_o = vcnt_q < cfg_q.vsync_a;
  assign vert_sync_phase_b_o = vcnt_q < cfg_q.vsync_b;
  // only 0..2047 active lines are meaningful, top bit ignored
  assign line_active_o = (vcnt_q >= cfg_q.frame_offset) &&
                         ({1'b0, vcnt_q} < act_end);
  assign frame_start_o = pix_en_o && vcnt_q == '0 && hcnt_q == '0;

  // ----------------------------------------------------------------
  // display list swap handshake
  // ----------------------------------------------------------------
  lcd_vt_pkg::swap_e swap_q;
  lcd_vt_pkg::swap_e swap_d;
  logic [1:0] swap_code_q;
  wire swap_done = (swap_q == lcd_vt_pkg::SWAP_WAIT_LINE && line_end) ||
                   (swap_q == lcd_vt_pkg::SWAP_WAIT_FRAME && frame_end);

  // illegal codes 00 and 11 are left to the host and ignored
  always_comb begin
    swap_d = swap_q;
    case (swap_q)
      lcd_vt_pkg::SWAP_IDLE: begin
        if (wr_swap && wdata_i[1:0] == lcd_vt_pkg::SWAP_LINE) begin
          swap_d = lcd_vt_pkg::SWAP_WAIT_LINE;
        end else if (wr_swap && wdata_i[1:0] == lcd_vt_pkg::SWAP_FRAME) begin
          swap_d = lcd_vt_pkg::SWAP_WAIT_FRAME;
        end
      end
      lcd_vt_pkg::SWAP_WAIT_LINE: begin
        if (line_end) swap_d = lcd_vt_pkg::SWAP_IDLE;
      end
      lcd_vt_pkg::SWAP_WAIT_FRAME: begin
        if (frame_end) swap_d = lcd_vt_pkg::SWAP_IDLE;
      end
      default: swap_d = lcd_vt_pkg::SWAP_IDLE;
    endcase
  end

  // pending code held until the swap happens
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      swap_q <= lcd_vt_pkg::SWAP_IDLE;
      swap_code_q <= 2'h0;
      list_swap_o <= 1'b0;
    end else begin
      swap_q <= swap_d;
      swap_code_q <= (swap_d == lcd_vt_pkg::SWAP_IDLE) ? 2'h0 :
                     (swap_d == lcd_vt_pkg::SWAP_WAIT_LINE) ? lcd_vt_pkg::SWAP_LINE :
                     lcd_vt_pkg::SWAP_FRAME;
      list_swap_o <= swap_done;
    end
  end

  // ----------------------------------------------------------------
  // pixel output path
  // ----------------------------------------------------------------
  lcd_vt_pkg::rgb_s src;
  assign src = line_active_o ? pix_i : '0;

  color_conditioner u_color (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .en_i(pix_en_o),
    .dither_i(output_dither_enable_q),
    .lines_i(color_line_counts_q),
    .arrange_i(rgb_pin_arrangement_q),
    .pos_i({vcnt_q[0], hcnt_q[0]}),
    .pix_i(src),
    .pix_o(rgb_o)
  );

  // ----------------------------------------------------------------
  // read mux, data in the cycle after the strobe
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    case (addr_i)
      lcd_vt_pkg::LINE_TOTAL_OFS: rd_mux = {20'h00000, line_total_cycles_q};
      lcd_vt_pkg::FRAME_TOTAL_OFS: rd_mux = {20'h00000, cfg_q.frame_total};
      lcd_vt_pkg::FRAME_OFFSET_OFS: rd_mux = {20'h00000, cfg_q.frame_offset};
      lcd_vt_pkg::FRAME_ACTIVE_OFS: rd_mux = {20'h00000, cfg_q.frame_active};
      lcd_vt_pkg::VSYNC_A_OFS: rd_mux = {20'h00000, cfg_q.vsync_a};
      lcd_vt_pkg::VSYNC_B_OFS: rd_mux = {20'h00000, cfg_q.vsync_b};
      lcd_vt_pkg::SWAP_OFS: rd_mux = {30'h00000000, swap_code_q};
      lcd_vt_pkg::ROTATE_OFS: rd_mux = {29'h00000000, screen_rotation_setting_q};
      lcd_vt_pkg::COLOR_LINES_OFS: rd_mux = {23'h000000, color_line_counts_q};
      lcd_vt_pkg::DITHER_OFS: rd_mux = {31'h00000000, output_dither_enable_q};
      lcd_vt_pkg::ARRANGE_OFS: rd_mux = {28'h0000000, rgb_pin_arrangement_q};
      lcd_vt_pkg::PCLK_DIV_OFS: rd_mux = {24'h000000, pclk_div_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // read data stands one cycle only
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rd_i ? rd_mux : 32'h00000000;
    end
  end
  assign rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_frame_req;
    wr_swap && wdata_i[1:0] == lcd_vt_pkg::SWAP_FRAME && swap_q == lcd_vt_pkg::SWAP_IDLE;
  endsequence

  a_swap_line_pending: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    swap_q == lcd_vt_pkg::SWAP_WAIT_LINE && !line_end |=> swap_code_q == 2'h1)
    else $error("line swap not reported pending");
  a_swap_frame_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_frame_req |=> swap_code_q == 2'h2) else $error("frame swap not pending");
  a_swap_frame_wait: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    swap_q == lcd_vt_pkg::SWAP_WAIT_FRAME && line_end && !frame_end |=> swap_code_q != 2'h0)
    else $error("frame swap ended early");
  a_swap_zero_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    swap_code_q == 2'h0 |-> swap_q == lcd_vt_pkg::SWAP_IDLE || $past(swap_done))
    else $error("swap reads zero while pending");
  a_line_wrap: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    frame_end |=> vcnt_q == '0) else $error("line counter did not wrap");
  a_line_step: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    line_end && !frame_end |=> vcnt_q == $past(vcnt_q) + 1'b1)
    else $error("line counter did not advance");
  a_dither_read: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rd_i && addr_i == lcd_vt_pkg::DITHER_OFS |=> rdata_o[0] == output_dither_enable_q)
    else $error("dither readback wrong");
  a_sync_b_region: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    vcnt_q == '0 && cfg_q.vsync_b != '0 |-> vert_sync_phase_b_o)
    else $error("sync phase b missing at frame start");
  a_active_start: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    vcnt_q < cfg_q.frame_offset |-> !line_active_o)
    else $error("active before offset");

endmodule

//--- tb/lcd_panel_model.sv
// Purpose: passive panel that measures each frame in pixel enables
// Assumes: frame_start_o marks line 0 column 0 together with pix_en_o
// Notes: counts are those of the last complete frame
`timescale 1ns/1ps
module lcd_panel_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // panel pins
  input wire logic pix_en_i,
  input wire logic sync_a_i,
  input wire logic sync_b_i,
  input wire logic active_i,
  input wire logic frame_start_i,
  // measured frame
  output logic [15:0] total_o,
  output logic [15:0] active_o,
  output logic [15:0] sync_a_o,
  output logic [15:0] sync_b_o,
  output logic [15:0] first_o
);
  logic [15:0] tot_q, act_q, sa_q, sb_q, first_q;
  // --------------------------------------------------------------
  // per-frame tallies, latched at each frame start
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      {tot_q, act_q, sa_q, sb_q, first_q} <= '0;
      {total_o, active_o, sync_a_o, sync_b_o, first_o} <= '0;
    end else if (pix_en_i && frame_start_i) begin
      total_o <= tot_q;
      active_o <= act_q;
      sync_a_o <= sa_q;
      sync_b_o <= sb_q;
      first_o <= first_q;
      tot_q <= 16'h1;
      act_q <= {15'h0, active_i};
      sa_q <= {15'h0, sync_a_i};
      sb_q <= {15'h0, sync_b_i};
      first_q <= active_i ? 16'h0 : 16'hffff;
    end else if (pix_en_i) begin
      tot_q <= tot_q + 16'h1;
      act_q <= act_q + {15'h0, active_i};
      sa_q <= sa_q + {15'h0, sync_a_i};
      sb_q <= sb_q + {15'h0, sync_b_i};
      // first active enable of the frame, as an index
      if (active_i && first_q == 16'hffff) first_q <= tot_q;
    end
  end
endmodule

//--- tb/lcd_vert_timing_test.sv
// Purpose: self-checking bench for the vertical timing block
// Assumes: line of 8 pixels, pixel enable every 2 clocks
// Notes: small timing values keep each frame at 96 clocks
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", nm, exp, got); end end
module lcd_vert_timing_test;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] rst; logic [31:0] rb;} row_t;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, d;
  lcd_vt_pkg::rgb_s pix_i = '0, rgb_o, e;
  logic pix_en_o, sa_o, sb_o, act_o, fs_o, list_swap_o;
  logic [2:0] rot_o;
  logic [15:0] m_tot, m_act, m_sa, m_sb, m_first;
  int n_fail = 0, tests_run = 0, cyc = 0, k;
  row_t rows [13];
  lcd_vert_timing lcd_vert_timing_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pix_i(pix_i),
    .pix_en_o(pix_en_o), .vert_sync_phase_a_o(sa_o), .vert_sync_phase_b_o(sb_o),
    .line_active_o(act_o), .frame_start_o(fs_o), .rgb_o(rgb_o), .list_swap_o(list_swap_o),
    .screen_rotation_setting_o(rot_o));
  lcd_panel_model lcd_panel_model_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .pix_en_i(pix_en_o), .sync_a_i(sa_o), .sync_b_i(sb_o), .active_i(act_o),
    .frame_start_i(fs_o), .total_o(m_tot), .active_o(m_act), .sync_a_o(m_sa),
    .sync_b_o(m_sb), .first_o(m_first));
  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // bus cycles and waits
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= w;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 r = rdata_o;
  endtask
  // bounded wait for one cycle where the flag stands high
  task automatic wait_hi(ref logic s, input int lim, output int n);
    n = 0;
    do begin
      @(posedge ref_clk_i);
      #1 n++;
    end while (s !== 1'b1 && n < lim);
  endtask
  // next active pixel, sampled on the cycle after its enable
  task automatic pix_chk(input lcd_vt_pkg::rgb_s x);
    do begin
      @(posedge ref_clk_i);
      #1;
    end while (!(pix_en_o === 1'b1 && act_o === 1'b1));
    @(posedge ref_clk_i);
    #1 `CHK("rgb_o", x, rgb_o)
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rows = '{'{8'h2c, 32'hfffff008, 32'h224, 32'h8}, '{8'h40, 32'h6, 32'h124, 32'h6},
      '{8'h44, 32'h2, 32'hc, 32'h2}, '{8'h48, 32'hfffff003, 32'h110, 32'h3},
      '{8'h4c, 32'h1, 32'h0, 32'h1}, '{8'h50, 32'h2, 32'ha, 32'h2},
      '{8'h54, 32'h0, 32'h0, 32'h0}, '{8'h58, 32'hfffffffd, 32'h0, 32'h5},
      '{8'h5c, 32'hfffffe00, 32'h0, 32'h0}, '{8'h60, 32'hfffffffe, 32'h1, 32'h0},
      '{8'h64, 32'hfffffff3, 32'h0, 32'h3}, '{8'h80, 32'hffffffff, 32'h0, 32'h0},
      '{8'h70, 32'h2, 32'h0, 32'h2}};
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    // divider zero after reset: the pixel enable stays low
    wait_hi(pix_en_o, 50, k);
    `CHK("pix_en_o", 50, k)
    // reset values, then write and read back through every row
    foreach (rows[i]) begin
      rd(rows[i].a, d);
      `CHK("reset", rows[i].rst, d)
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      `CHK("readback", rows[i].rb, d)
    end
    `CHK("rotation", 3'h5, rot_o)
    $display("register test done");
    // frame shape as the panel sees it, two frames after setup
    wait_hi(fs_o, 300, k);
    wait_hi(fs_o, 300, k);
    wait_hi(fs_o, 300, k);
    #1;
    `CHK("frame pixels", 16'd48, m_tot)
    `CHK("active pixels", 16'd24, m_act)
    `CHK("first active", 16'd16, m_first)
    `CHK("sync a pixels", 16'd8, m_sa)
    `CHK("sync b pixels", 16'd16, m_sb)
    $display("frame test done");
    // arrangement codes with full width, dither off
    pix_i <= '{r: 8'h12, g: 8'h34, b: 8'h56};
    for (int c = 0; c < 6; c++) begin
      wr(8'h64, c);
      case (c)
        0: e = '{8'h12, 8'h34, 8'h56};
        1: e = '{8'h12, 8'h56, 8'h34};
        2: e = '{8'h34, 8'h12, 8'h56};
        3: e = '{8'h34, 8'h56, 8'h12};
        4: e = '{8'h56, 8'h12, 8'h34};
        default: e = '{8'h56, 8'h34, 8'h12};
      endcase
      pix_chk(e);
    end
    wr(8'h64, 32'h0);
    // red four lines, green three, blue zero meaning eight
    wr(8'h5c, 32'h118);
    pix_chk('{8'h10, 8'h20, 8'h56});
    // dither on at full width leaves pixels untouched
    wr(8'h5c, 32'h0);
    wr(8'h60, 32'h1);
    pix_chk('{8'h12, 8'h34, 8'h56});
    $display("pixel test done");
    // line swap: pending reads nonzero, done within one line
    // start at a line start so the pending read lands before the line ends
    wait_hi(fs_o, 300, k);
    wr(8'h54, 32'h1);
    rd(8'h54, d);
    `CHK("swap pending", 32'h1, d)
    wait_hi(list_swap_o, 20, k);
    `CHK("line swap", 1'b1, list_swap_o)
    rd(8'h54, d);
    `CHK("swap done", 32'h0, d)
    // frame swap: still pending mid-frame, done by frame end
    wait_hi(fs_o, 300, k);
    wr(8'h54, 32'h2);
    repeat (40) @(posedge ref_clk_i);
    rd(8'h54, d);
    `CHK("frame pending", 32'h2, d)
    wait_hi(list_swap_o, 70, k);
    `CHK("frame swap", 1'b1, list_swap_o)
    rd(8'h54, d);
    `CHK("swap done", 32'h0, d)
    $display("swap test done");
    // second reset restores defaults
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(8'h40, d);
    `CHK("total after reset", 32'h124, d)
    rd(8'h60, d);
    `CHK("dither after reset", 32'h1, d)
    $display("reset test done");
    complete_run();
  end
endmodule
